// file: include/dpt_pkg.sv
/*
  Constants, field layout and state type for the delay and pulse timers.
  Assumes a 20 MHz system clock and an APB register bus with 32-bit data.
*/
package dpt_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int CLK_HZ       = 20000000;
  localparam int TICK_TIME_MS = 10;
  localparam int TICK_CYC     = (CLK_HZ / 1000) * TICK_TIME_MS;
  localparam int TICKS_PER_S  = 100;
  localparam int S_PER_MIN    = 60;

  // ----------------------------------------------------------------------
  // Time values
  // ----------------------------------------------------------------------
  localparam int              VAL_W   = 17;
  localparam int              REF_W   = 18;
  localparam int              NREF    = 4;
  localparam logic [VAL_W-1:0] MAX_MS  = 17'h1869E;  // 99998
  localparam logic [VAL_W-1:0] MAX_SM  = 17'h0176F;  // 5999
  localparam logic [VAL_W-1:0] STEP_MS = 17'h0000A;  // 10 ms per tick
  localparam logic [VAL_W-1:0] STEP_1  = 17'h00001;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_TH    = 8'h04;
  localparam logic [7:0] OFS_TL    = 8'h08;
  localparam logic [7:0] OFS_TRT   = 8'h0C;
  localparam logic [7:0] OFS_TWP   = 8'h10;
  localparam logic [7:0] OFS_STAT  = 8'h14;
  localparam logic [7:0] OFS_EL_OO = 8'h18;
  localparam logic [7:0] OFS_EL_RT = 8'h1C;
  localparam logic [7:0] OFS_EL_WP = 8'h20;

  // ----------------------------------------------------------------------
  // Time configuration word layout and reset values
  // ----------------------------------------------------------------------
  localparam int CFG_W        = 23;
  localparam int CFG_LIVE_BIT = 17;
  localparam int CFG_BLK_LSB  = 18;
  localparam int CFG_TB_LSB   = 21;
  localparam int CTRL_W       = 3;
  localparam logic [CFG_W-1:0]  CFG_RST  = 23'h200001;  // 1 s constant
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;

  typedef enum logic [1:0] {
    TB_MS,
    TB_S,
    TB_M
  } dpt_tb_t;

  typedef struct packed {
    logic [2:0]              trg_s1;
    logic [2:0]              trg_s2;
    logic [2:0]              trg_d;
    logic                    rst_s1;
    logic                    rst_s2;
    logic                    pwr_s1;
    logic                    pwr_s2;
    logic                    pwr_d;
    logic [17:0]             pre_cnt;
    logic [6:0]              sec_cnt;
    logic [5:0]              min_cnt;
    logic [2:0]              tick;
    logic [CTRL_W-1:0]       ret;
    logic [3:0][CFG_W-1:0]   cfg;
    logic                    oo_q;
    logic                    oo_on_run;
    logic                    oo_off_run;
    logic [VAL_W-1:0]        oo_el;
    logic                    rt_q;
    logic                    rt_run;
    logic [VAL_W-1:0]        rt_el;
    logic                    wp_q;
    logic                    wp_run;
    logic [VAL_W-1:0]        wp_el;
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } dpt_state_t;

endpackage

// file: src/dpt_timers.sv
/*
  On/off-delay, retentive on-delay and pulse-output timers with an APB
  register slave. Assumes trigger, reset and restore inputs may come from
  outside the clock domain; APB and live values are on CLK.
*/
// The implementer's own choices: the APB register port and the register addresses.
// Summary of operation
// - Trigger rising edge starts on-delay timing against the high delay.
// - Trigger falling edge starts off-delay timing against the low delay.
// - Output sets when high delay expires with trigger held high.
// - Trigger low before high delay expires clears elapsed time, no set.
// - Output clears when low delay expires with trigger held low.
// - Trigger high before low delay expires clears elapsed, output stays set.
// - Retentive blocks keep output and elapsed time across power loss.
// - Each duration is a constant or a selected block's live value.
// - Retentive on-delay starts on rising edge, sets output at equality.
// - Running or expired retentive timer ignores further trigger activity.
// - Reset input clears retentive output and elapsed time; so does power restore when block is not retentive.
// - Pulse output sets on trigger, holds while trigger high and running.
// - Pulse output clears when the pulse duration expires.
// - Out-of-range live values are clamped to the time base limits.
`timescale 1ns/1ps
module dpt_timers #(
  parameter int P_TICK_CYCLES = dpt_pkg::TICK_CYC
) (
  input  wire logic                                     CLK,
  input  wire logic                                     RSTN,
  input  wire logic                                     PSEL,
  input  wire logic                                     PENABLE,
  input  wire logic                                     PWRITE,
  input  wire logic [7:0]                               PADDR,
  input  wire logic [31:0]                              PWDATA,
  output logic      [31:0]                              PRDATA,
  output logic                                          PREADY,
  output logic                                          PSLVERR,
  input  wire logic                                     ONOFF_TRG,
  input  wire logic                                     RETON_TRG,
  input  wire logic                                     RETON_RST,
  input  wire logic                                     PULSE_TRG,
  input  wire logic                                     PWR_RESTORE,
  input  wire logic [dpt_pkg::NREF-1:0][dpt_pkg::REF_W-1:0] REF_VALUE,
  output logic                                          ONOFF_Q,
  output logic                                          RETON_Q,
  output logic                                          PULSE_Q
);

  dpt_pkg::dpt_state_t s;
  dpt_pkg::dpt_state_t n;

  logic [7:0][dpt_pkg::REF_W-1:0] refs;
  logic [3:0][dpt_pkg::VAL_W-1:0] tval;
  logic [3:0][dpt_pkg::VAL_W-1:0] tstep;
  logic [3:0]                     ttick;

  // ----------------------------------------------------------------------
  // Duration sources: 0 high delay, 1 low delay, 2 retentive, 3 pulse
  // ----------------------------------------------------------------------
  // Own elapsed times are selectable as live values, blocks 4 to 6
  assign refs = {{dpt_pkg::REF_W{1'b0}}, {1'b0, s.wp_el}, {1'b0, s.rt_el},
                 {1'b0, s.oo_el}, REF_VALUE};

  for (genvar i = 0; i < 4; i++) begin : g_tsel
    dpt_tsel u_tsel (
      .cfg  (s.cfg[i]),
      .refs (refs),
      .ticks(s.tick),
      .val  (tval[i]),
      .tick (ttick[i]),
      .step (tstep[i])
    );
  end

  logic                         acc;
  logic                         hit;
  logic [31:0]                  rdv;
  logic                         restore;
  logic [2:0]                   rise;
  logic [2:0]                   fall;
  logic [3:0][dpt_pkg::VAL_W:0] sum;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    n = s;
    // Inputs from other logic blocks may be asynchronous: two stages
    n.trg_s1 = {PULSE_TRG, RETON_TRG, ONOFF_TRG};
    n.trg_s2 = s.trg_s1;
    n.trg_d  = s.trg_s2;
    n.rst_s1 = RETON_RST;
    n.rst_s2 = s.rst_s1;
    n.pwr_s1 = PWR_RESTORE;
    n.pwr_s2 = s.pwr_s1;
    n.pwr_d  = s.pwr_s2;
    rise     = s.trg_s2 & ~s.trg_d;
    fall     = ~s.trg_s2 & s.trg_d;
    restore  = s.pwr_s2 & ~s.pwr_d;
    sum[0]   = {1'b0, s.oo_el} + {1'b0, tstep[0]};
    sum[1]   = {1'b0, s.oo_el} + {1'b0, tstep[1]};
    sum[2]   = {1'b0, s.rt_el} + {1'b0, tstep[2]};
    sum[3]   = {1'b0, s.wp_el} + {1'b0, tstep[3]};

    // Shared time base: 10 ms, 1 s and 1 min ticks
    n.tick = 3'h0;
    if (32'(s.pre_cnt) >= P_TICK_CYCLES - 1) begin
      n.pre_cnt = '0;
      n.tick[0] = 1'b1;
      if (32'(s.sec_cnt) >= dpt_pkg::TICKS_PER_S - 1) begin
        n.sec_cnt = '0;
        n.tick[1] = 1'b1;
        if (32'(s.min_cnt) >= dpt_pkg::S_PER_MIN - 1) begin
          n.min_cnt = '0;
          n.tick[2] = 1'b1;
        end else begin
          n.min_cnt = s.min_cnt + 6'h01;
        end
      end else begin
        n.sec_cnt = s.sec_cnt + 7'h01;
      end
    end else begin
      n.pre_cnt = s.pre_cnt + 18'h00001;
    end

    // On/off-delay
    if (rise[0]) begin
      n.oo_on_run  = 1'b1;
      n.oo_off_run = 1'b0;
      n.oo_el      = '0;
    end else if (fall[0]) begin
      n.oo_on_run  = 1'b0;
      n.oo_off_run = s.oo_q;
      n.oo_el      = '0;
    end else if (s.oo_on_run && ttick[0]) begin
      if (sum[0] >= {1'b0, tval[0]}) begin
        n.oo_q      = 1'b1;
        n.oo_on_run = 1'b0;
        n.oo_el     = tval[0];
      end else begin
        n.oo_el = sum[0][dpt_pkg::VAL_W-1:0];
      end
    end else if (s.oo_off_run && ttick[1]) begin
      if (sum[1] >= {1'b0, tval[1]}) begin
        n.oo_q       = 1'b0;
        n.oo_off_run = 1'b0;
        n.oo_el      = tval[1];
      end else begin
        n.oo_el = sum[1][dpt_pkg::VAL_W-1:0];
      end
    end

    // Retentive on-delay; reset input has priority over everything
    if (s.rst_s2) begin
      n.rt_q   = 1'b0;
      n.rt_run = 1'b0;
      n.rt_el  = '0;
    end else if (rise[1] && !s.rt_run && !s.rt_q) begin
      n.rt_run = 1'b1;
      n.rt_el  = '0;
    end else if (s.rt_run && ttick[2]) begin
      if (sum[2] >= {1'b0, tval[2]}) begin
        n.rt_q   = 1'b1;
        n.rt_run = 1'b0;
        n.rt_el  = tval[2];
      end else begin
        n.rt_el = sum[2][dpt_pkg::VAL_W-1:0];
      end
    end

    // Pulse output: a trigger drop ends the pulse early
    if (rise[2]) begin
      n.wp_q   = 1'b1;
      n.wp_run = 1'b1;
      n.wp_el  = '0;
    end else if (fall[2]) begin
      n.wp_q   = 1'b0;
      n.wp_run = 1'b0;
    end else if (s.wp_run && ttick[3]) begin
      if (sum[3] >= {1'b0, tval[3]}) begin
        n.wp_q   = 1'b0;
        n.wp_run = 1'b0;
        n.wp_el  = tval[3];
      end else begin
        n.wp_el = sum[3][dpt_pkg::VAL_W-1:0];
      end
    end

    // Power restore: only non-retentive blocks fall back to defaults
    if (restore && !s.ret[0]) begin
      n.oo_q       = 1'b0;
      n.oo_on_run  = 1'b0;
      n.oo_off_run = 1'b0;
      n.oo_el      = '0;
    end
    if (restore && !s.ret[1]) begin
      n.rt_q   = 1'b0;
      n.rt_run = 1'b0;
      n.rt_el  = '0;
    end
    if (restore && !s.ret[2]) begin
      n.wp_q   = 1'b0;
      n.wp_run = 1'b0;
      n.wp_el  = '0;
    end

    // APB: one wait state, answer registered
    acc = PSEL && PENABLE;
    hit = 1'b1;
    rdv = 32'h0;
    unique case (PADDR)
      dpt_pkg::OFS_CTRL:  rdv = 32'(s.ret);
      dpt_pkg::OFS_TH:    rdv = 32'(s.cfg[0]);
      dpt_pkg::OFS_TL:    rdv = 32'(s.cfg[1]);
      dpt_pkg::OFS_TRT:   rdv = 32'(s.cfg[2]);
      dpt_pkg::OFS_TWP:   rdv = 32'(s.cfg[3]);
      dpt_pkg::OFS_STAT:  rdv = {26'h0, s.wp_run, s.rt_run, s.oo_off_run | s.oo_on_run,
                                 s.wp_q, s.rt_q, s.oo_q};
      dpt_pkg::OFS_EL_OO: rdv = 32'(s.oo_el);
      dpt_pkg::OFS_EL_RT: rdv = 32'(s.rt_el);
      dpt_pkg::OFS_EL_WP: rdv = 32'(s.wp_el);
      default:            hit = 1'b0;
    endcase
    n.pready  = acc && !s.pready;
    n.pslverr = acc && !s.pready && !hit;
    n.prdata  = (acc && !s.pready && !PWRITE) ? rdv : 32'h0;
    if (acc && s.pready && PWRITE) begin
      unique case (PADDR)
        dpt_pkg::OFS_CTRL: n.ret    = PWDATA[dpt_pkg::CTRL_W-1:0];
        dpt_pkg::OFS_TH:   n.cfg[0] = PWDATA[dpt_pkg::CFG_W-1:0];
        dpt_pkg::OFS_TL:   n.cfg[1] = PWDATA[dpt_pkg::CFG_W-1:0];
        dpt_pkg::OFS_TRT:  n.cfg[2] = PWDATA[dpt_pkg::CFG_W-1:0];
        dpt_pkg::OFS_TWP:  n.cfg[3] = PWDATA[dpt_pkg::CFG_W-1:0];
        default:           n.ret    = s.ret;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s        <= '0;
      s.ret    <= dpt_pkg::CTRL_RST;
      s.cfg    <= {4{dpt_pkg::CFG_RST}};
    end else begin
      s <= n;
    end
  end

  assign PRDATA  = s.prdata;
  assign PREADY  = s.pready;
  assign PSLVERR = s.pslverr;
  assign ONOFF_Q = s.oo_q;
  assign RETON_Q = s.rt_q;
  assign PULSE_Q = s.wp_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  a_onoff_set_held: assert property (
    $rose(s.oo_q) |-> $past(s.trg_s2[0]) && $past(s.oo_on_run))
    else $error("on/off output set without held trigger");
  a_onoff_on_abort: assert property (
    s.oo_on_run && !s.trg_s2[0] |=> !s.oo_on_run && s.oo_el == '0)
    else $error("on-delay not cleared by trigger drop");
  a_onoff_off_abort: assert property (
    s.oo_off_run && s.trg_s2[0] && !restore |=> s.oo_q && !s.oo_off_run)
    else $error("off-delay abort lost output");
  a_onoff_clr_low: assert property (
    $fell(s.oo_q) && !$past(restore) |-> !$past(s.trg_s2[0]))
    else $error("on/off output cleared with trigger high");
  // Live durations may move; compare with the value used at expiry
  a_reton_set_equal: assert property (
    $rose(s.rt_q) |-> s.rt_el == $past(tval[2]) && $past(s.rt_run))
    else $error("retentive output set at wrong time");
  a_reton_hold: assert property (
    s.rt_q && !s.rst_s2 && !restore |=> s.rt_q && $stable(s.rt_el))
    else $error("expired retentive timer disturbed");
  a_reton_reset: assert property (s.rst_s2 |=> !s.rt_q && s.rt_el == '0 && !s.rt_run)
    else $error("retentive reset did not clear");
  a_pulse_start: assert property ($rose(s.wp_q) |-> $past(rise[2]))
    else $error("pulse output set without trigger edge");
  a_pulse_expire: assert property (
    s.wp_run && ttick[3] && sum[3] >= {1'b0, tval[3]} && !rise[2] && !fall[2]
    |=> !s.wp_q)
    else $error("pulse did not end at expiry");
  a_clamp_range: assert property (
    tval[0] <= ((s.cfg[0][dpt_pkg::CFG_TB_LSB +: 2] == 2'h0) ? dpt_pkg::MAX_MS
                                                              : dpt_pkg::MAX_SM))
    else $error("high delay not clamped");
  a_tick_advance: assert property (
    s.rt_el != $past(s.rt_el) && s.rt_el != '0 |-> $past(ttick[2]))
    else $error("elapsed time moved without tick");
  a_apb_wait_one: assert property (acc && !s.pready |=> s.pready ##1 !s.pready)
    else $error("APB answer timing wrong");

  c_onoff_cycle: cover property ($fell(s.oo_q));
  c_reton_set:   cover property ($rose(s.rt_q));
  c_pulse_end:   cover property ($fell(s.wp_q) && s.trg_s2[2]);
  c_apb_err:     cover property (s.pslverr);

endmodule

// file: src/dpt_tsel.sv
/*
  Time value source for one timer: constant or live block value, clamped
  to the range of its time base, plus the tick and step of that base.
  Assumes ticks are one-cycle pulses from the shared time base.
*/
`timescale 1ns/1ps
module dpt_tsel (
  input  wire logic [dpt_pkg::CFG_W-1:0]        cfg,
  input  wire logic [7:0][dpt_pkg::REF_W-1:0]   refs,
  input  wire logic [2:0]                       ticks,
  output logic      [dpt_pkg::VAL_W-1:0]        val,
  output logic                                  tick,
  output logic      [dpt_pkg::VAL_W-1:0]        step
);

  logic [dpt_pkg::REF_W-1:0] raw;
  logic [dpt_pkg::VAL_W-1:0] lim;
  logic [1:0]                tb;

  always_comb begin
    tb  = cfg[dpt_pkg::CFG_TB_LSB +: 2];
    // Live value picked by block number, else the stored constant
    raw = cfg[dpt_pkg::CFG_LIVE_BIT] ? refs[cfg[dpt_pkg::CFG_BLK_LSB +: 3]]
                                     : {1'b0, cfg[dpt_pkg::VAL_W-1:0]};
    lim = (tb == dpt_pkg::TB_MS) ? dpt_pkg::MAX_MS : dpt_pkg::MAX_SM;
    // Negative live values go to zero, large ones to the limit
    if (raw[dpt_pkg::REF_W-1]) begin
      val = '0;
    end else if (raw[dpt_pkg::VAL_W-1:0] > lim) begin
      val = lim;
    end else begin
      val = raw[dpt_pkg::VAL_W-1:0];
    end
    unique case (tb)
      dpt_pkg::TB_MS: begin
        tick = ticks[0];
        step = dpt_pkg::STEP_MS;
      end
      dpt_pkg::TB_S: begin
        tick = ticks[1];
        step = dpt_pkg::STEP_1;
      end
      dpt_pkg::TB_M: begin
        tick = ticks[2];
        step = dpt_pkg::STEP_1;
      end
      default: begin
        // Unused code ticks and steps as milliseconds but clamps to the s/min limit
        tick = ticks[0];
        step = dpt_pkg::STEP_MS;
      end
    endcase
  end

endmodule

// file: tb/dpt_blk_src.sv
/*
  Behavioural stand-in for the neighbouring function blocks: trigger,
  reset and restore levels and the live values of blocks 0..3.
  Assumes the bench calls its tasks from the CLK domain.
*/
`timescale 1ns/1ps
module dpt_blk_src (
  input  wire logic         clk,
  output logic              onoff_trg,
  output logic              reton_trg,
  output logic              reton_rst,
  output logic              pulse_trg,
  output logic              pwr_restore,
  output logic [3:0][17:0]  ref_value
);
  initial begin
    onoff_trg   = 1'b0;
    reton_trg   = 1'b0;
    reton_rst   = 1'b0;
    pulse_trg   = 1'b0;
    pwr_restore = 1'b0;
    ref_value   = '0;
  end

  // ----------------------------------------------------------------------
  // Level changes, always just after an edge
  // ----------------------------------------------------------------------
  task automatic put(input int sel, input logic v);
    @(posedge clk);
    case (sel)
      0: onoff_trg <= v;
      1: reton_trg <= v;
      2: reton_rst <= v;
      3: pulse_trg <= v;
      default: pwr_restore <= v;
    endcase
  endtask

  task automatic put_ref(input int idx, input logic [17:0] v);
    @(posedge clk);
    ref_value[idx] <= v;
  endtask
endmodule

// file: tb/tb_delay_and_pulse_timers.sv
/*
  Self-checking bench for the delay and pulse timers: APB register
  accesses plus trigger sequences from the block source model.
  Assumes a tick every 4 clocks, so 10 ms of timer time is 4 cycles.
*/
`timescale 1ns/1ps
module tb_delay_and_pulse_timers;
  logic                     clk;
  logic                     rstn;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [7:0]               paddr;
  logic [31:0]              pwdata;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     onoff_trg;
  logic                     reton_trg;
  logic                     reton_rst;
  logic                     pulse_trg;
  logic                     pwr_restore;
  logic [3:0][17:0]         ref_value;
  logic                     onoff_q;
  logic                     reton_q;
  logic                     pulse_q;
  logic [31:0]              rd;
  logic                     err;
  logic [7:0]               ofs [9];
  int                       n_errors = 0;
  int                       checks = 0;
  int                       cyc = 0;

  dpt_timers #(.P_TICK_CYCLES(4)) i_dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .ONOFF_TRG(onoff_trg), .RETON_TRG(reton_trg),
    .RETON_RST(reton_rst), .PULSE_TRG(pulse_trg), .PWR_RESTORE(pwr_restore),
    .REF_VALUE(ref_value), .ONOFF_Q(onoff_q), .RETON_Q(reton_q), .PULSE_Q(pulse_q)
  );

  dpt_blk_src i_src (
    .clk(clk), .onoff_trg(onoff_trg), .reton_trg(reton_trg), .reton_rst(reton_rst),
    .pulse_trg(pulse_trg), .pwr_restore(pwr_restore), .ref_value(ref_value)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Report and hang guard
  // ----------------------------------------------------------------------
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Whole run is near 900 cycles, the longest wait at most 820
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_errors++;
      $display("[ERR] run length expected below 8000 seen 8000");
      end_sim();
    end
  end

  task automatic chk32(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic qv(input int sel);
    case (sel)
      0: return onoff_q;
      1: return reton_q;
      default: return pulse_q;
    endcase
  endfunction

  // Cycles until an output reaches a level must fall inside a window
  task automatic wait_q(input string nm, input int sel, input logic v, input int lo,
                        input int hi);
    int n;
    n = 0;
    while (qv(sel) !== v && n <= hi) begin
      @(posedge clk);
      n++;
    end
    checks++;
    if (n < lo || n > hi) begin
      n_errors++;
      $display("[ERR] %s expected %0d..%0d cycles seen %0d", nm, lo, hi, n);
    end
  endtask

  // ----------------------------------------------------------------------
  // APB master: setup, access until pready, then one idle cycle
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      $display("[ERR] pready expected 1 seen 0");
    end
    @(posedge clk);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rstn = 1'b0;
    ofs = '{dpt_pkg::OFS_CTRL, dpt_pkg::OFS_TH, dpt_pkg::OFS_TL, dpt_pkg::OFS_TRT,
            dpt_pkg::OFS_TWP, dpt_pkg::OFS_STAT, dpt_pkg::OFS_EL_OO,
            dpt_pkg::OFS_EL_RT, dpt_pkg::OFS_EL_WP};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ofs[i], 32'h0);
      chk32("reset value", (i >= 1 && i <= 4) ? {9'h0, dpt_pkg::CFG_RST} : 32'h0, rd);
      chk32("mapped read error", 32'h0, {31'h0, err});
    end
    apb(1'b1, dpt_pkg::OFS_STAT, 32'h3F);
    apb(1'b0, dpt_pkg::OFS_STAT, 32'h0);
    chk32("status after write", 32'h0, rd);
    apb(1'b0, 8'h24, 32'h0);
    chk32("unmapped read error", 32'h1, {31'h0, err});
    chk32("unmapped read data", 32'h0, rd);
    // Unmapped writes are refused and must not leak into a register
    apb(1'b1, 8'h24, 32'h7);
    chk32("unmapped write error", 32'h1, {31'h0, err});
    apb(1'b0, dpt_pkg::OFS_CTRL, 32'h0);
    chk32("ctrl after unmapped write", 32'h0, rd);
    $display("test registers done");

    apb(1'b1, dpt_pkg::OFS_TH, 32'h32);
    apb(1'b1, dpt_pkg::OFS_TL, 32'h1E);
    apb(1'b0, dpt_pkg::OFS_TH, 32'h0);
    chk32("on delay cfg", 32'h32, rd);
    i_src.put(0, 1'b1);
    repeat (10) @(posedge clk);
    i_src.put(0, 1'b0);
    repeat (40) @(posedge clk);
    chk32("onoff after short high", 32'h0, {31'h0, onoff_q});
    apb(1'b0, dpt_pkg::OFS_EL_OO, 32'h0);
    chk32("onoff elapsed cleared", 32'h0, rd);
    i_src.put(0, 1'b1);
    wait_q("onoff set", 0, 1'b1, 17, 25);
    repeat (8) @(posedge clk);
    i_src.put(0, 1'b0);
    repeat (6) @(posedge clk);
    i_src.put(0, 1'b1);
    repeat (30) @(posedge clk);
    chk32("onoff after short low", 32'h1, {31'h0, onoff_q});
    i_src.put(0, 1'b0);
    wait_q("onoff clear", 0, 1'b0, 10, 18);
    $display("test on off delay done");

    apb(1'b1, dpt_pkg::OFS_TRT, 32'h32);
    i_src.put(1, 1'b1);
    repeat (6) @(posedge clk);
    i_src.put(1, 1'b0);
    wait_q("reton set", 1, 1'b1, 10, 18);
    apb(1'b0, dpt_pkg::OFS_EL_RT, 32'h0);
    chk32("reton elapsed at expiry", 32'h32, rd);
    i_src.put(1, 1'b1);
    repeat (10) @(posedge clk);
    i_src.put(1, 1'b0);
    repeat (10) @(posedge clk);
    apb(1'b0, dpt_pkg::OFS_EL_RT, 32'h0);
    chk32("reton elapsed retrig", 32'h32, rd);
    chk32("reton q held", 32'h1, {31'h0, reton_q});
    i_src.put(2, 1'b1);
    wait_q("reton clear", 1, 1'b0, 2, 5);
    i_src.put(2, 1'b0);
    apb(1'b0, dpt_pkg::OFS_EL_RT, 32'h0);
    chk32("reton elapsed reset", 32'h0, rd);
    $display("test retentive on delay done");

    apb(1'b1, dpt_pkg::OFS_TWP, 32'h32);
    i_src.put(3, 1'b1);
    wait_q("pulse set", 2, 1'b1, 2, 5);
    wait_q("pulse end", 2, 1'b0, 13, 22);
    i_src.put(3, 1'b0);
    i_src.put_ref(1, 18'h0001E);
    apb(1'b1, dpt_pkg::OFS_TWP, 32'h00060000);
    i_src.put(3, 1'b1);
    wait_q("live pulse set", 2, 1'b1, 2, 5);
    wait_q("live pulse end", 2, 1'b0, 6, 14);
    i_src.put(3, 1'b0);
    i_src.put_ref(2, 18'h3FFFF);
    apb(1'b1, dpt_pkg::OFS_TWP, 32'h000A0000);
    i_src.put(3, 1'b1);
    repeat (15) @(posedge clk);
    chk32("negative clamp q", 32'h0, {31'h0, pulse_q});
    apb(1'b0, dpt_pkg::OFS_EL_WP, 32'h0);
    chk32("negative clamp elapsed", 32'h0, rd);
    i_src.put(3, 1'b0);
    apb(1'b1, dpt_pkg::OFS_TWP, 32'h00200002);
    i_src.put(3, 1'b1);
    wait_q("s pulse set", 2, 1'b1, 2, 5);
    wait_q("s pulse end", 2, 1'b0, 390, 820);
    i_src.put(3, 1'b0);
    // Trigger drop while the long pulse runs ends it early
    i_src.put(3, 1'b1);
    wait_q("drop pulse set", 2, 1'b1, 2, 5);
    i_src.put(3, 1'b0);
    wait_q("drop pulse end", 2, 1'b0, 2, 5);
    $display("test pulse done");

    apb(1'b1, dpt_pkg::OFS_CTRL, 32'h2);
    i_src.put(0, 1'b1);
    wait_q("onoff set again", 0, 1'b1, 17, 25);
    i_src.put(1, 1'b1);
    wait_q("reton set again", 1, 1'b1, 17, 25);
    i_src.put(4, 1'b1);
    repeat (6) @(posedge clk);
    chk32("restore onoff q", 32'h0, {31'h0, onoff_q});
    chk32("restore reton q", 32'h1, {31'h0, reton_q});
    apb(1'b0, dpt_pkg::OFS_EL_OO, 32'h0);
    chk32("restore onoff elapsed", 32'h0, rd);
    apb(1'b0, dpt_pkg::OFS_EL_RT, 32'h0);
    chk32("restore reton elapsed", 32'h32, rd);
    apb(1'b0, dpt_pkg::OFS_STAT, 32'h0);
    chk32("restore status", 32'h2, rd);
    i_src.put(4, 1'b0);
    i_src.put(0, 1'b0);
    $display("test retentivity done");
    end_sim();
  end
endmodule
